// [rtl/tlm_monitor.sv]
// Temperature limit monitor: Wishbone register file, limits and fan events
// What this block does
// [R1] Writable over-temperature enables, channel 1 resets set
// [R2] Read-only alert enables in bits 5-7, zero
// [R3] Sensor kind bits; 1 diode, reset to 1
// [R4] Channel 1 hysteresis 0-15, release at limit-hys
// [R5] Channel 3/2 hysteresis, reset 2 and 4
// [R6] Read-only open flags for channels 3 and 2
// [R7] Channel 1 fault on open/short diode path
// [R8] Channel 1 fault on missing sideband acknowledge
// [R9] Channel 1 fault on digital interface error code
// [R10] Live readings at 72h, 74h, 76h
// [R11] Channel 1 over-temperature limit, reset 64h
// [R12] Channel 1 high limit, reset 55h, alert compare
// [R13] Channel 2 limits, reset 64h and 55h
// [R14] Channel 3 limits, reset 55h and 46h
// [R15] Two-bit filter depth per channel, reset 0
// [R16] Per-fan wake enables, reset 0
// [R17] Fan status sticky on overrun, write-1 clears
// [R18] Over-temperature set above limit, hysteresis release
// [R19] Wake output is OR of enabled fan status
`timescale 1ns/1ps
module tlm_monitor #(
  parameter int ADR_W = 10
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic [2:0][7:0]  chan_reading_i,
  input  wire logic             chan1_diode_fault_i,
  input  wire logic             chan1_ack_missing_i,
  input  wire logic             chan1_error_code_i,
  input  wire logic             chan2_open_i,
  input  wire logic             chan3_open_i,
  input  wire logic [2:0]       fan_overrun_i,
  output logic      [2:0]       overtemp_o,
  output logic      [2:0]       alert_o,
  output logic                  overtemp_shutdown_o,
  output logic                  fan_wake_o,
  output logic                  irq_o
);

  // ==========================================================================
  // State
  localparam int SYNC_W = 32;

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [31:0]       dat;
    logic              ack;
    logic [2:0]        hot_en;
    logic [2:0]        kind;
    logic [2:0][3:0]   hys;
    logic [2:0][7:0]   hot_lim;
    logic [2:0][7:0]   hi_lim;
    logic [5:0]        filter;
    logic [2:0]        fan_en;
    logic [2:0]        fan_sts;
    logic [1:0]        iface;
    logic [5:0]        irq_sts;
    logic [5:0]        irq_mask;
    logic [2:0]        hot;
    logic [2:0]        alert;
    logic              shutdown;
    logic              wake;
    logic              irq;
  } tlm_state_t;

  tlm_state_t state_reg;
  tlm_state_t state_next;

  // Limit tracker with hysteresis; sum is 9 bits so reading+hys never wraps
  function automatic logic limit_track(input logic       active,
                                       input logic [7:0] reading,
                                       input logic [7:0] limit,
                                       input logic [3:0] hys);
    logic [8:0] sum;
    sum = {1'b0, reading} + {5'h00, hys};
    if (reading > limit) begin
      limit_track = 1'b1;
    end else if (sum <= {1'b0, limit}) begin
      limit_track = 1'b0;
    end else begin
      limit_track = active;
    end
  endfunction

  // ==========================================================================
  // Synchronised pin inputs (read only from sync2)
  logic [2:0][7:0] reading;
  logic            s_diode_fault;
  logic            s_ack_missing;
  logic            s_error_code;
  logic            s_open2;
  logic            s_open3;
  logic [2:0]      s_fan_overrun;
  logic            ch1_fault;
  logic [7:0]      idx;
  logic            bus_req;
  logic            wr;
  logic [7:0]      wbyte;
  logic [7:0]      rbyte;
  logic [5:0]      irq_event;

  // Multi-bit readings change slowly; a torn sample lasts one cycle only
  assign reading       = state_reg.sync2[23:0];
  assign s_diode_fault = state_reg.sync2[24];
  assign s_ack_missing = state_reg.sync2[25];
  assign s_error_code  = state_reg.sync2[26];
  assign s_open2       = state_reg.sync2[27];
  assign s_open3       = state_reg.sync2[28];
  assign s_fan_overrun = state_reg.sync2[31:29];

  assign idx     = wb_adr_i[9:2];
  assign bus_req = wb_cyc_i & wb_stb_i & ~state_reg.ack;
  assign wr      = bus_req & wb_we_i & wb_sel_i[0];
  assign wbyte   = wb_dat_i[7:0];

  // Channel 1 abnormality from whichever path is active
  assign ch1_fault =
    (state_reg.kind[0] == tlm_pkg::KIND_DIODE && s_diode_fault) | // [R7]
    (state_reg.iface[tlm_pkg::SB_EN_BIT] && s_ack_missing) |      // [R8]
    (state_reg.iface[tlm_pkg::DIG_EN_BIT] && s_error_code);       // [R9]

  // ==========================================================================
  // Read multiplexer
  always_comb begin
    rbyte = 8'h00;
    unique case (idx)
      tlm_pkg::IDX_HOT_ALERT_EN: begin
        rbyte = (8'(state_reg.hot_en) << tlm_pkg::HOT_EN_LSB)       // [R1]
              | (8'(tlm_pkg::ALERT_EN_RST) << tlm_pkg::ALERT_EN_LSB); // [R2]
      end
      tlm_pkg::IDX_SENSOR_TYPE:
        rbyte = 8'(state_reg.kind) << tlm_pkg::KIND_LSB;            // [R3]
      tlm_pkg::IDX_CH1_HYS:
        rbyte = 8'(state_reg.hys[0]) << tlm_pkg::HYS_HI_LSB;        // [R4]
      tlm_pkg::IDX_CH23_HYS: begin
        rbyte = (8'(state_reg.hys[2]) << tlm_pkg::HYS_HI_LSB)       // [R5]
              | 8'(state_reg.hys[1]);
      end
      tlm_pkg::IDX_FAULT_STATUS:
        rbyte = 8'({s_open3, s_open2, ch1_fault})                   // [R6]
                << tlm_pkg::FAULT_LSB;
      tlm_pkg::IDX_CH1_READING:  rbyte = reading[0];                // [R10]
      tlm_pkg::IDX_CH2_READING:  rbyte = reading[1];                // [R10]
      tlm_pkg::IDX_CH3_READING:  rbyte = reading[2];                // [R10]
      tlm_pkg::IDX_CH1_HOT_LIM:  rbyte = state_reg.hot_lim[0];      // [R11]
      tlm_pkg::IDX_CH1_HIGH_LIM: rbyte = state_reg.hi_lim[0];       // [R12]
      tlm_pkg::IDX_CH2_HOT_LIM:  rbyte = state_reg.hot_lim[1];      // [R13]
      tlm_pkg::IDX_CH2_HIGH_LIM: rbyte = state_reg.hi_lim[1];       // [R13]
      tlm_pkg::IDX_CH3_HOT_LIM:  rbyte = state_reg.hot_lim[2];      // [R14]
      tlm_pkg::IDX_CH3_HIGH_LIM: rbyte = state_reg.hi_lim[2];       // [R14]
      tlm_pkg::IDX_FILTER_SEL:
        rbyte = 8'(state_reg.filter) << tlm_pkg::FILTER_LSB;        // [R15]
      tlm_pkg::IDX_FAN_WAKE_EN:  rbyte = 8'(state_reg.fan_en);      // [R16]
      tlm_pkg::IDX_FAN_STATUS:   rbyte = 8'(state_reg.fan_sts);     // [R17]
      tlm_pkg::IDX_IFACE_CTRL:   rbyte = 8'(state_reg.iface);
      tlm_pkg::IDX_IRQ_STATUS:   rbyte = 8'(state_reg.irq_sts);
      tlm_pkg::IDX_IRQ_MASK:     rbyte = 8'(state_reg.irq_mask);
      default:                   rbyte = 8'h00;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    state_next.sync1 = {fan_overrun_i, chan3_open_i, chan2_open_i,
                        chan1_error_code_i, chan1_ack_missing_i,
                        chan1_diode_fault_i, chan_reading_i};
    state_next.sync2 = state_reg.sync1;

    // Single-cycle ack; ack drops the cycle after it was given
    state_next.ack = bus_req;
    state_next.dat = bus_req ? {24'h00_0000, rbyte} : 32'h0000_0000;

    // Register writes
    if (wr) begin
      unique case (idx)
        tlm_pkg::IDX_HOT_ALERT_EN:
          state_next.hot_en = wbyte[tlm_pkg::HOT_EN_LSB +: 3];      // [R1]
        tlm_pkg::IDX_SENSOR_TYPE:
          state_next.kind = wbyte[tlm_pkg::KIND_LSB +: 3];          // [R3]
        tlm_pkg::IDX_CH1_HYS:
          state_next.hys[0] = wbyte[tlm_pkg::HYS_HI_LSB +: 4];      // [R4]
        tlm_pkg::IDX_CH23_HYS: begin
          state_next.hys[2] = wbyte[tlm_pkg::HYS_HI_LSB +: 4];      // [R5]
          state_next.hys[1] = wbyte[3:0];                           // [R5]
        end
        tlm_pkg::IDX_CH1_HOT_LIM:  state_next.hot_lim[0] = wbyte;   // [R11]
        tlm_pkg::IDX_CH1_HIGH_LIM: state_next.hi_lim[0]  = wbyte;   // [R12]
        tlm_pkg::IDX_CH2_HOT_LIM:  state_next.hot_lim[1] = wbyte;   // [R13]
        tlm_pkg::IDX_CH2_HIGH_LIM: state_next.hi_lim[1]  = wbyte;   // [R13]
        tlm_pkg::IDX_CH3_HOT_LIM:  state_next.hot_lim[2] = wbyte;   // [R14]
        tlm_pkg::IDX_CH3_HIGH_LIM: state_next.hi_lim[2]  = wbyte;   // [R14]
        tlm_pkg::IDX_FILTER_SEL:
          state_next.filter = wbyte[tlm_pkg::FILTER_LSB +: 6];      // [R15]
        tlm_pkg::IDX_FAN_WAKE_EN:  state_next.fan_en = wbyte[2:0];  // [R16]
        tlm_pkg::IDX_FAN_STATUS:
          state_next.fan_sts = state_reg.fan_sts & ~wbyte[2:0];     // [R17]
        tlm_pkg::IDX_IFACE_CTRL:   state_next.iface = wbyte[1:0];
        tlm_pkg::IDX_IRQ_STATUS:
          state_next.irq_sts = state_reg.irq_sts & ~wbyte[5:0];
        tlm_pkg::IDX_IRQ_MASK:     state_next.irq_mask = wbyte[5:0];
        default: ;
      endcase
    end

    // Fan overrun sets after any clear so a same-cycle event is kept
    state_next.fan_sts = state_next.fan_sts | s_fan_overrun;        // [R17]

    // Limit trackers; channels with hot_en clear drop only their over-temperature indication
    for (int c = 0; c < 3; c++) begin
      state_next.hot[c] = state_reg.hot_en[c] &                     // [R18]
        limit_track(state_reg.hot[c], reading[c],
                    state_reg.hot_lim[c], state_reg.hys[c]);        // [R4]
      state_next.alert[c] = limit_track(state_reg.alert[c],         // [R12]
        reading[c], state_reg.hi_lim[c], state_reg.hys[c]);         // [R5]
    end

    // Rising edges of either indication are interrupt events
    irq_event = {state_next.alert & ~state_reg.alert,
                 state_next.hot & ~state_reg.hot};
    state_next.irq_sts = state_next.irq_sts | irq_event;
    state_next.irq = |(state_next.irq_sts & state_next.irq_mask);
    state_next.shutdown = |state_next.hot;
    state_next.wake = |(state_next.fan_sts & state_next.fan_en);    // [R19]
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg          <= '0;
      state_reg.hot_en   <= tlm_pkg::HOT_EN_RST;                    // [R1]
      state_reg.kind     <= tlm_pkg::KIND_RST;                      // [R3]
      state_reg.hys[0]   <= tlm_pkg::CH1_HYS_RST;
      state_reg.hys[1]   <= tlm_pkg::CH2_HYS_RST;                   // [R5]
      state_reg.hys[2]   <= tlm_pkg::CH3_HYS_RST;                   // [R5]
      state_reg.hot_lim[0] <= tlm_pkg::CH1_HOT_RST;                 // [R11]
      state_reg.hi_lim[0]  <= tlm_pkg::CH1_HI_RST;                  // [R12]
      state_reg.hot_lim[1] <= tlm_pkg::CH2_HOT_RST;                 // [R13]
      state_reg.hi_lim[1]  <= tlm_pkg::CH2_HI_RST;                  // [R13]
      state_reg.hot_lim[2] <= tlm_pkg::CH3_HOT_RST;                 // [R14]
      state_reg.hi_lim[2]  <= tlm_pkg::CH3_HI_RST;                  // [R14]
      state_reg.filter   <= tlm_pkg::FILTER_RST;                    // [R15]
      state_reg.fan_en   <= tlm_pkg::FAN_EN_RST;                    // [R16]
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_dat_o            = state_reg.dat;
  assign wb_ack_o            = state_reg.ack;
  assign overtemp_o          = state_reg.hot;
  assign alert_o             = state_reg.alert;
  assign overtemp_shutdown_o = state_reg.shutdown;
  assign fan_wake_o          = state_reg.wake;
  assign irq_o               = state_reg.irq;

  // ==========================================================================
  // Checks
  property p_hot_set;
    @(posedge clk_i) disable iff (rst_i)
      (state_reg.hot_en[0] && reading[0] > state_reg.hot_lim[0])
      |=> overtemp_o[0];
  endproperty
  a_hot_set: assert property (p_hot_set) // [R18]
    else $error("over-temperature not raised above limit");

  property p_hot_release;
    @(posedge clk_i) disable iff (rst_i)
      ({1'b0, reading[1]} + {5'h00, state_reg.hys[1]}
        <= {1'b0, state_reg.hot_lim[1]}) |=> !overtemp_o[1];
  endproperty
  a_hot_release: assert property (p_hot_release) // [R5]
    else $error("over-temperature held below release point");

  property p_hot_disabled;
    @(posedge clk_i) disable iff (rst_i)
      !state_reg.hot_en[2] |=> !overtemp_o[2];
  endproperty
  a_hot_disabled: assert property (p_hot_disabled) // [R1]
    else $error("disabled channel shows over-temperature");

  property p_alert_set;
    @(posedge clk_i) disable iff (rst_i)
      (reading[0] > state_reg.hi_lim[0]) |=> alert_o[0];
  endproperty
  a_alert_set: assert property (p_alert_set) // [R12]
    else $error("alert not raised above high limit");

  property p_alert_hold;
    @(posedge clk_i) disable iff (rst_i)
      (alert_o[0] && reading[0] <= state_reg.hi_lim[0] &&
       {1'b0, reading[0]} + {5'h00, state_reg.hys[0]}
        > {1'b0, state_reg.hi_lim[0]}) |=> alert_o[0];
  endproperty
  a_alert_hold: assert property (p_alert_hold) // [R4]
    else $error("alert released inside hysteresis band");

  property p_fan_sticky;
    @(posedge clk_i) disable iff (rst_i)
      (s_fan_overrun != 3'h0)
      |=> (state_reg.fan_sts & $past(s_fan_overrun)) == $past(s_fan_overrun);
  endproperty
  a_fan_sticky: assert property (p_fan_sticky) // [R17]
    else $error("fan status lost an overrun");

  property p_fan_hold;
    @(posedge clk_i) disable iff (rst_i)
      (state_reg.fan_sts[1] && !(wr && idx == tlm_pkg::IDX_FAN_STATUS))
      |=> state_reg.fan_sts[1];
  endproperty
  a_fan_hold: assert property (p_fan_hold) // [R17]
    else $error("fan status cleared without a write");

  property p_wake;
    @(posedge clk_i) disable iff (rst_i)
      fan_wake_o == |(state_reg.fan_sts & state_reg.fan_en);
  endproperty
  a_wake: assert property (p_wake) // [R19]
    else $error("wake output disagrees with enabled status");

  property p_ack_one;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack held for more than one cycle");

  property p_read_limit;
    @(posedge clk_i) disable iff (rst_i)
      (bus_req && !wb_we_i && idx == tlm_pkg::IDX_CH3_HOT_LIM)
      |=> wb_ack_o && wb_dat_o[7:0] == $past(state_reg.hot_lim[2]);
  endproperty
  a_read_limit: assert property (p_read_limit) // [R14]
    else $error("limit read returned wrong value");

  property p_fault1;
    @(posedge clk_i) disable iff (rst_i)
      (bus_req && !wb_we_i && idx == tlm_pkg::IDX_FAULT_STATUS &&
       state_reg.kind[0] && s_diode_fault) |=> wb_dat_o[tlm_pkg::FAULT_LSB];
  endproperty
  a_fault1: assert property (p_fault1) // [R7]
    else $error("channel 1 diode fault not reported");

  property p_open2;
    @(posedge clk_i) disable iff (rst_i)
      (bus_req && !wb_we_i && idx == tlm_pkg::IDX_FAULT_STATUS && s_open2)
      |=> wb_dat_o[tlm_pkg::FAULT_LSB + 1];
  endproperty
  a_open2: assert property (p_open2) // [R6]
    else $error("channel 2 open diode not reported");

  property p_shutdown;
    @(posedge clk_i) disable iff (rst_i)
      overtemp_shutdown_o == |overtemp_o;
  endproperty
  a_shutdown: assert property (p_shutdown) // [R18]
    else $error("shutdown disagrees with over-temperature levels");

  // Level output, so it must track the masked status in every cycle
  property p_irq_level;
    @(posedge clk_i) disable iff (rst_i)
      irq_o == |(state_reg.irq_sts & state_reg.irq_mask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level disagrees with masked status");

endmodule : tlm_monitor

// [rtl/tlm_pkg.sv]
// Constants for the temperature limit monitor register block
package tlm_pkg;
  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_HOT_ALERT_EN  = 8'h66;
  localparam logic [7:0] IDX_SENSOR_TYPE   = 8'h6B;
  localparam logic [7:0] IDX_CH1_HYS       = 8'h6C;
  localparam logic [7:0] IDX_CH23_HYS      = 8'h6D;
  localparam logic [7:0] IDX_FAULT_STATUS  = 8'h6F;
  localparam logic [7:0] IDX_CH1_READING   = 8'h72;
  localparam logic [7:0] IDX_CH2_READING   = 8'h74;
  localparam logic [7:0] IDX_CH3_READING   = 8'h76;
  localparam logic [7:0] IDX_CH1_HOT_LIM   = 8'h82;
  localparam logic [7:0] IDX_CH1_HIGH_LIM  = 8'h83;
  localparam logic [7:0] IDX_CH2_HOT_LIM   = 8'h84;
  localparam logic [7:0] IDX_CH2_HIGH_LIM  = 8'h85;
  localparam logic [7:0] IDX_CH3_HOT_LIM   = 8'h86;
  localparam logic [7:0] IDX_CH3_HIGH_LIM  = 8'h87;
  localparam logic [7:0] IDX_FILTER_SEL    = 8'h8E;
  localparam logic [7:0] IDX_FAN_WAKE_EN   = 8'h90;
  localparam logic [7:0] IDX_FAN_STATUS    = 8'h91;
  localparam logic [7:0] IDX_IFACE_CTRL    = 8'hA0;
  localparam logic [7:0] IDX_IRQ_STATUS    = 8'hA1;
  localparam logic [7:0] IDX_IRQ_MASK      = 8'hA2;

  // ==========================================================================
  // Field positions
  localparam int HOT_EN_LSB   = 1;
  localparam int ALERT_EN_LSB = 5;
  localparam int KIND_LSB     = 1;
  localparam int HYS_HI_LSB   = 4;
  localparam int FAULT_LSB    = 1;
  localparam int FILTER_LSB   = 2;
  localparam int SB_EN_BIT    = 0;
  localparam int DIG_EN_BIT   = 1;

  // ==========================================================================
  // Reset values
  localparam logic [2:0] HOT_EN_RST  = 3'h1;
  localparam logic [2:0] ALERT_EN_RST = 3'h0;
  localparam logic [2:0] KIND_RST    = 3'h7;
  localparam logic [3:0] CH1_HYS_RST = 4'h0;
  localparam logic [3:0] CH2_HYS_RST = 4'h4;
  localparam logic [3:0] CH3_HYS_RST = 4'h2;
  localparam logic [7:0] CH1_HOT_RST = 8'h64;
  localparam logic [7:0] CH1_HI_RST  = 8'h55;
  localparam logic [7:0] CH2_HOT_RST = 8'h64;
  localparam logic [7:0] CH2_HI_RST  = 8'h55;
  localparam logic [7:0] CH3_HOT_RST = 8'h55;
  localparam logic [7:0] CH3_HI_RST  = 8'h46;
  localparam logic [5:0] FILTER_RST  = 6'h00;
  localparam logic [2:0] FAN_EN_RST  = 3'h0;

  // Sensor kind codes
  localparam logic KIND_THERMISTOR = 1'b0;
  localparam logic KIND_DIODE      = 1'b1;
endpackage : tlm_pkg

// [sim/tlm_sensor_model.sv]
// Far-side model: sensor front ends, sideband links and fan counters
`timescale 1ns/1ps
module tlm_sensor_model (
  input  wire logic            clk_i,
  input  wire logic [2:0][7:0] set_reading_i,
  input  wire logic [4:0]      set_fault_i,
  input  wire logic [2:0]      set_fan_i,
  output logic      [2:0][7:0] reading_o = '0,
  output logic      [4:0]      fault_o = '0,
  output logic      [2:0]      fan_o = '0
);
  // ==========================================================================
  // Pins
  // Fault bits: 0 diode path, 1 missing ack, 2 error code, 3/4 open ch2/ch3
  // Pins move just after an edge, as real front-end logic would
  always @(posedge clk_i) begin
    reading_o <= set_reading_i;
    fault_o   <= set_fault_i;
    fan_o     <= set_fan_i;
  end
endmodule // tlm_sensor_model

// [sim/temperature_limit_monitor_bench.sv]
// Self-checking bench for the temperature limit monitor
`timescale 1ns/1ps
module temperature_limit_monitor_bench;
  logic            clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            cyc = 1'b0;
  logic            stb = 1'b0;
  logic            we = 1'b0;
  logic [9:0]      adr = '0;
  logic [3:0]      sel = '0;
  logic [31:0]     wdat = '0;
  logic [31:0]     rdat;
  logic            ack;
  logic [2:0][7:0] set_rd = '0;
  logic [4:0]      set_flt = '0;
  logic [2:0]      set_fan = '0;
  logic [2:0][7:0] rd_pin;
  logic [4:0]      flt_pin;
  logic [2:0]      fan_pin;
  logic [2:0]      hot;
  logic [2:0]      alrt;
  logic            shut;
  logic            wake;
  logic            irq;
  int              num_errors = 0;
  int              n_checks = 0;
  int              cyc_count = 0;

  tlm_monitor #(.ADR_W(10)) tlm_monitor_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .chan_reading_i(rd_pin),
    .chan1_diode_fault_i(flt_pin[0]), .chan1_ack_missing_i(flt_pin[1]),
    .chan1_error_code_i(flt_pin[2]), .chan2_open_i(flt_pin[3]),
    .chan3_open_i(flt_pin[4]), .fan_overrun_i(fan_pin),
    .overtemp_o(hot), .alert_o(alrt), .overtemp_shutdown_o(shut),
    .fan_wake_o(wake), .irq_o(irq));

  tlm_sensor_model tlm_sensor_model_i (
    .clk_i(clk_i), .set_reading_i(set_rd), .set_fault_i(set_flt),
    .set_fan_i(set_fan), .reading_o(rd_pin), .fault_o(flt_pin),
    .fan_o(fan_pin));

  // ==========================================================================
  // Clock, timeout and verdict
  initial begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // A hung bus would otherwise stall the run forever
  always @(posedge clk_i) begin
    cyc_count++;
    if (cyc_count == 20000) begin
      num_errors++;
      close_out();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Classic cycle; ack is read before this edge's updates land
  task automatic wb(input logic w, input logic [7:0] idx,
                    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    sel  <= 4'h1;
    wdat <= {24'h00_0000, d};
    // Only the bench-wide timeout ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, idx, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    wb(1'b0, idx, 8'h00, q);
    check(q, exp);
  endtask

  // Pins need two sync edges plus one for the limit logic
  task automatic settle();
    repeat (6) @(posedge clk_i);
  endtask

  task automatic pins(input logic [7:0] a, b, c);
    set_rd <= {c, b, a};
    settle();
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rd_chk(8'h66, 8'h02);
    rd_chk(8'h6B, 8'h0E);
    rd_chk(8'h6C, 8'h00);
    rd_chk(8'h6D, 8'h24);
    rd_chk(8'h6F, 8'h00);
    rd_chk(8'h82, 8'h64);
    rd_chk(8'h83, 8'h55);
    rd_chk(8'h84, 8'h64);
    rd_chk(8'h85, 8'h55);
    rd_chk(8'h86, 8'h55);
    rd_chk(8'h87, 8'h46);
    rd_chk(8'h8E, 8'h00);
    rd_chk(8'h90, 8'h00);
    rd_chk(8'h91, 8'h00);
  endtask

  task automatic t_access();
    wr(8'h66, 8'hFF);
    rd_chk(8'h66, 8'h0E);
    wr(8'h6B, 8'h00);
    rd_chk(8'h6B, 8'h00);
    wr(8'h6C, 8'hFF);
    rd_chk(8'h6C, 8'hF0);
    wr(8'h6D, 8'h9A);
    rd_chk(8'h6D, 8'h9A);
    wr(8'h6F, 8'hFF);
    rd_chk(8'h6F, 8'h00);
    wr(8'h8E, 8'hFF);
    rd_chk(8'h8E, 8'hFC);
    wr(8'h90, 8'hFF);
    rd_chk(8'h90, 8'h07);
    wr(8'h87, 8'h3C);
    rd_chk(8'h87, 8'h3C);
    wr(8'h10, 8'h55);
    rd_chk(8'h10, 8'h00);
    wr(8'h66, 8'h02);
    wr(8'h6B, 8'h0E);
    wr(8'h90, 8'h00);
  endtask

  task automatic t_read();
    pins(8'h19, 8'h2A, 8'h3B);
    rd_chk(8'h72, 8'h19);
    rd_chk(8'h74, 8'h2A);
    rd_chk(8'h76, 8'h3B);
    pins(8'h1C, 8'h2A, 8'h3B);
    rd_chk(8'h72, 8'h1C);
  endtask

  task automatic t_fault();
    set_flt <= 5'b00010;
    settle();
    rd_chk(8'h6F, 8'h00);
    wr(tlm_pkg::IDX_IFACE_CTRL, 8'h01);
    settle();
    rd_chk(8'h6F, 8'h02);
    set_flt <= 5'b00100;
    wr(tlm_pkg::IDX_IFACE_CTRL, 8'h02);
    settle();
    rd_chk(8'h6F, 8'h02);
    set_flt <= 5'b00001;
    wr(tlm_pkg::IDX_IFACE_CTRL, 8'h00);
    settle();
    rd_chk(8'h6F, 8'h02);
    set_flt <= 5'b11000;
    settle();
    rd_chk(8'h6F, 8'h0C);
    set_flt <= 5'b00000;
  endtask

  task automatic t_ovt();
    wr(8'h6C, 8'h50);
    wr(8'h82, 8'h50);
    wr(tlm_pkg::IDX_IRQ_MASK, 8'h01);
    // Channel 2 runs hot but its over-temperature path is disabled
    pins(8'h51, 8'h70, 8'h00);
    check({5'h0, hot}, 8'h01);
    check({7'h0, shut}, 8'h01);
    check({5'h0, alrt}, 8'h02);
    check({7'h0, irq}, 8'h01);
    rd_chk(tlm_pkg::IDX_IRQ_STATUS, 8'h11);
    pins(8'h4C, 8'h70, 8'h00);
    check({5'h0, hot}, 8'h01);
    pins(8'h4B, 8'h70, 8'h00);
    check({5'h0, hot}, 8'h00);
    wr(tlm_pkg::IDX_IRQ_STATUS, 8'h01);
    settle();
    check({7'h0, irq}, 8'h00);
    rd_chk(tlm_pkg::IDX_IRQ_STATUS, 8'h10);
    pins(8'h56, 8'h00, 8'h00);
    check({5'h0, alrt}, 8'h01);
    wr(tlm_pkg::IDX_IRQ_MASK, 8'h00);
  endtask

  task automatic t_fan();
    set_fan <= 3'b010;
    settle();
    set_fan <= 3'b000;
    settle();
    rd_chk(8'h91, 8'h02);
    check({7'h0, wake}, 8'h00);
    wr(8'h90, 8'h02);
    settle();
    check({7'h0, wake}, 8'h01);
    wr(8'h91, 8'h00);
    rd_chk(8'h91, 8'h02);
    wr(8'h91, 8'h02);
    rd_chk(8'h91, 8'h00);
    settle();
    check({7'h0, wake}, 8'h00);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_access();
    t_read();
    t_fault();
    t_ovt();
    t_fan();
    close_out();
  end
endmodule // temperature_limit_monitor_bench
